// >>> common/rgbws_pkg.sv
package rgbws_pkg;

    // clock and oscillator timing
    localparam int unsigned CLK_NS = 8;
    localparam int unsigned OSC_NS = 1000;
    localparam int unsigned OSC_DIV = (OSC_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned EXT_NS = 32000;
    localparam int unsigned EXT_STEP = EXT_NS / OSC_NS;
    localparam int unsigned CKO_FAST_NS = 2000;
    localparam int unsigned CKO_SLOW_NS = 16000;
    localparam int unsigned CKO_FAST_CYC = CKO_FAST_NS / CLK_NS;
    localparam int unsigned CKO_SLOW_CYC = CKO_SLOW_NS / CLK_NS;

    // cycle lengths in oscillator ticks (1 us each), codes 0..7
    localparam logic [7:0][24:0] CYCLE_TICKS_DEF = {
        25'h1000000, 25'h0C00000, 25'h0800000, 25'h0400000,
        25'h0200000, 25'h0100000, 25'h0080000, 25'h0020000};

    // register indices, byte address is four times the index
    localparam logic [7:0] IDX_RUN = 8'h01;
    localparam logic [7:0] IDX_D1_LO = 8'h02;
    localparam logic [7:0] IDX_D1_HI = 8'h0B;
    localparam logic [7:0] IDX_D2_LO = 8'h0C;
    localparam logic [7:0] IDX_D2_HI = 8'h15;
    localparam logic [7:0] IDX_SUPPLY = 8'h41;
    localparam logic [7:0] IDX_CLKCFG = 8'h42;
    localparam logic [7:0] IDX_STATUS = 8'h43;

    // run register fields, driver one then driver two
    localparam int unsigned B_RUN1 = 0;
    localparam int unsigned B_OS1 = 1;
    localparam int unsigned B_SYNC1 = 2;
    localparam int unsigned B_RUN2 = 4;
    localparam int unsigned B_OS2 = 5;
    localparam int unsigned B_SYNC2 = 6;

    // clock pin configuration fields
    localparam int unsigned B_CKEN = 0;
    localparam int unsigned B_CKDIR = 1;
    localparam int unsigned B_CLOCK_RATE_SELECT = 2;
    localparam int unsigned B_SLP = 3;
    localparam int unsigned B_SRST = 7;

    // timing register fields
    localparam int unsigned F_CYC = 0;
    localparam int unsigned F_RISE = 4;
    localparam int unsigned F_FALL = 6;

    localparam logic [7:0] PAT_INIT = 8'h07;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // reset image of the setting registers
    function automatic logic [21:1][7:0] rgbws_regs_init();
        logic [21:1][7:0] r;
        r = '0;
        for (int i = 2; i <= 21; i++) begin
            if (((i - 2) % 10) != 0 && (((i - 2) % 10) % 3) == 0) begin
                r[i] = PAT_INIT;
            end
        end
        return r;
    endfunction : rgbws_regs_init

endpackage : rgbws_pkg

// >>> hw/rgbws_top.sv
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
// What this block does
// (R1) supply select routes LEDs to boosted rail
// (R2) host writes supply select only LEDs off
// (R3) battery LEDs excluded from boost feedback
// (R4) separate counters, reset clears both
// (R5) writes 02h-0Bh reset driver one counter
// (R6) writes 0Ch-15h reset driver two counter
// (R7) same-value write still resets counter
// (R8) run enable clear freezes counter
// (R9) continuous run or single-cycle trigger
// (R10) ext sync low blanks driver LEDs
// (R11) sixteen patterns choose level per part
// (R12) two seven-bit levels per channel
// (R13) polarity follows larger level
// (R14) step time is slope over steps
// (R15) rise slope on increase, fall on decrease
// (R16) clock pin modes, illegal combos unused
// (R17) sleep forces all currents zero
// (R18) clock generation runs during sleep
// (R19) supplier keeps clock three periods longer
// (R20) host keeps clock config while active
// (R21) pattern seven holds level one
// (R22) slope zero switches levels abruptly
// (R23) cycle field selects eight cycle lengths
// (R24) slope codes zero, /16, /8, /4
// (R25) counters tick from oscillator or ext clock
module rgbws_top
    import rgbws_pkg::*;
#(
    parameter int ADDR_W = 12,
    parameter logic [7:0][24:0] CYCLE_TICKS = CYCLE_TICKS_DEF
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [1:0] ext_sync_pin,
    input wire logic shared_clock_pin_i,
    output logic shared_clock_pin_o,
    output logic shared_clock_pin_oe,
    output logic [41:0] led_current,
    output logic [5:0] boost_feedback,
    output logic analog_off
);

    typedef struct packed {
        logic [21:1][7:0] regs;
        logic [7:0] supply;
        logic [7:0] cfg;
        logic awready;
        logic arready;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [31:0] rdata;
        logic [7:0] div;
        logic [2:0] ck;
        logic [1:0] sy1;
        logic [1:0] sy2;
        logic [10:0] ckcnt;
        logic cko;
        logic cko_oe;
        logic [1:0][24:0] wcnt;
        logic [5:0][6:0] lvl;
        logic [5:0][24:0] acc;
        logic [5:0] fb;
    } rgbws_st_t;

    localparam logic [21:1][7:0] REGS_INIT = rgbws_regs_init();

    rgbws_st_t st;
    rgbws_st_t next_st;

    logic tick;
    logic ext_edge;
    logic ext_mode;
    logic [5:0] stp;
    logic wr_hs;
    logic rd_hs;
    logic [7:0] widx;
    logic [7:0] ridx;
    logic [1:0] run;
    logic [1:0] run_en;
    logic [1:0] sync_sel;
    logic [1:0] wrap;
    logic [1:0][24:0] len;
    logic [1:0][24:0] rise_t;
    logic [1:0][24:0] fall_t;
    logic [1:0][1:0] quarter;
    logic [24:0] sum;
    logic [6:0] i1;
    logic [6:0] i2;
    logic [6:0] tgt;
    logic [6:0] diff;
    logic [24:0] sl;
    logic blank;
    logic [7:0] pat_cur;
    logic [7:0] pat_i1;
    logic [7:0] pat_i2;

    // register index from a byte address
    function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
        return a[9:2];
    endfunction : reg_index

    // pattern code 7 maps to all level one
    function automatic logic pat_level_two(input logic [3:0] p, input logic [1:0] q);
        logic [3:0] m;
        m = p ^ 4'h7;
        return m[q];
    endfunction : pat_level_two

    // supply select: channel 0 red, 1 green, 2 blue
    function automatic logic on_boost(input logic [1:0] sel, input int c);
        return {1'b0, sel} >= 3'(3 - c);
    endfunction : on_boost

    // slope code to ticks
    function automatic logic [24:0] slope_ticks(input logic [1:0] code, input logic [24:0] l);
        logic [24:0] r;
        unique case (code)
            2'h0: r = '0;
            2'h1: r = l >> 4;
            2'h2: r = l >> 3;
            2'h3: r = l >> 2;
        endcase
        return r;
    endfunction : slope_ticks

    ////////////////////////////////////////////////////////////////////////
    // next-state logic
    always_comb begin
        next_st = st;
        sum = '0;
        i1 = '0;
        i2 = '0;
        tgt = '0;
        diff = '0;
        sl = '0;
        blank = 1'b0;
        pat_cur = '0;
        pat_i1 = '0;
        pat_i2 = '0;
        wrap = '0;
        // oscillator divider and input synchronisers
        tick = st.div == 8'(OSC_DIV - 1);
        next_st.div = tick ? 8'h00 : st.div + 8'h01;
        next_st.ck = {st.ck[1:0], shared_clock_pin_i};
        next_st.sy1 = ext_sync_pin;
        next_st.sy2 = st.sy1;
        ext_edge = st.ck[1] & ~st.ck[2];
        ext_mode = st.cfg[B_CKEN] & ~st.cfg[B_CKDIR];
        // tick source selection
        if (ext_mode) begin // R25
            stp = ext_edge ? 6'(EXT_STEP) : 6'h00;
        end else begin
            stp = {5'h00, tick};
        end
        run_en = {st.regs[IDX_RUN][B_RUN2], st.regs[IDX_RUN][B_RUN1]};
        run = run_en | {st.regs[IDX_RUN][B_OS2], st.regs[IDX_RUN][B_OS1]}; // R9
        sync_sel = {st.regs[IDX_RUN][B_SYNC2], st.regs[IDX_RUN][B_SYNC1]};
        // per-driver waveform counters
        for (int d = 0; d < 2; d++) begin
            len[d] = CYCLE_TICKS[st.regs[2 + 10 * d][F_CYC +: 3]]; // R23
            rise_t[d] = slope_ticks(st.regs[2 + 10 * d][F_RISE +: 2], len[d]); // R24
            fall_t[d] = slope_ticks(st.regs[2 + 10 * d][F_FALL +: 2], len[d]);
            if (st.wcnt[d] >= (len[d] >> 1) + (len[d] >> 2)) begin
                quarter[d] = 2'h3;
            end else if (st.wcnt[d] >= (len[d] >> 1)) begin
                quarter[d] = 2'h2;
            end else if (st.wcnt[d] >= (len[d] >> 2)) begin
                quarter[d] = 2'h1;
            end else begin
                quarter[d] = 2'h0;
            end
            // a stopped driver keeps its count
            if (run[d] && stp != 6'h00) begin // R4 R8
                sum = st.wcnt[d] + {19'h0, stp};
                if (sum >= len[d]) begin
                    next_st.wcnt[d] = '0;
                    wrap[d] = 1'b1;
                    if (!run_en[d]) begin // R9
                        next_st.regs[IDX_RUN][d * 4 + B_OS1] = 1'b0;
                    end
                end else begin
                    next_st.wcnt[d] = sum;
                end
            end
        end
        // per-channel level and slope stepping
        for (int ch = 0; ch < 6; ch++) begin
            pat_i1 = 8'(2 + 10 * (ch / 3) + 1 + 3 * (ch % 3));
            pat_i2 = pat_i1 + 8'h01;
            pat_cur = pat_i1 + 8'h02;
            i1 = st.regs[pat_i1][6:0]; // R12
            i2 = st.regs[pat_i2][6:0];
            if (!run[ch / 3]) begin
                tgt = 7'h00;
            end else if (pat_level_two(st.regs[pat_cur][3:0], quarter[ch / 3])) begin
                tgt = i2; // R11 R21
            end else begin
                tgt = i1;
            end
            blank = st.cfg[B_SLP] | (sync_sel[ch / 3] & ~st.sy2[ch / 3]); // R10 R17
            diff = (i1 > i2) ? i1 - i2 : i2 - i1; // R13
            sl = (tgt > st.lvl[ch]) ? rise_t[ch / 3] : fall_t[ch / 3]; // R15
            if (blank || sl == '0 || diff == 7'h00) begin // R22
                next_st.lvl[ch] = blank ? 7'h00 : tgt;
                next_st.acc[ch] = '0;
            end else if (st.lvl[ch] == tgt) begin
                next_st.acc[ch] = '0;
            end else if (stp != 6'h00) begin
                // diff steps spread over sl ticks
                sum = st.acc[ch] + 25'(diff * stp); // R14
                if (sum >= sl) begin
                    next_st.acc[ch] = sum - sl;
                    next_st.lvl[ch] = (tgt > st.lvl[ch]) ? st.lvl[ch] + 7'h01
                                                         : st.lvl[ch] - 7'h01;
                end else begin
                    next_st.acc[ch] = sum;
                end
            end
            next_st.fb[ch] = on_boost(st.supply[(ch / 3) * 2 +: 2], ch % 3)
                             & (st.lvl[ch] != 7'h00); // R1 R3
        end
        // clock pin generator, always running
        if (st.ckcnt >= (st.cfg[B_CLOCK_RATE_SELECT] ? 11'(CKO_SLOW_CYC - 1) : 11'(CKO_FAST_CYC - 1))) begin
            next_st.ckcnt = '0; // R18
            next_st.cko = ~st.cko;
        end else begin
            next_st.ckcnt = st.ckcnt + 11'h001;
        end
        next_st.cko_oe = st.cfg[B_CKEN] & st.cfg[B_CKDIR]
                         & (st.cfg[B_CLOCK_RATE_SELECT] | ~st.cfg[B_SLP]); // R16
        // write channel
        widx = reg_index(s_axi_awaddr);
        wr_hs = st.awready & s_axi_awvalid & s_axi_wvalid;
        next_st.awready = s_axi_awvalid & s_axi_wvalid & ~st.awready & ~st.bvalid;
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (wr_hs) begin
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            if (s_axi_wstrb[0]) begin
                for (int i = 1; i <= 21; i++) begin
                    if (widx == 8'(i)) begin
                        next_st.regs[i] = s_axi_wdata[7:0];
                    end
                end
                if (widx == IDX_SUPPLY) begin
                    next_st.supply = {4'h0, s_axi_wdata[3:0]};
                end
                // any write with wstrb bit 0 set in a setting range restarts that driver
                if (widx >= IDX_D1_LO && widx <= IDX_D1_HI) begin // R5 R7
                    next_st.wcnt[0] = '0;
                    next_st.acc[2:0] = '0;
                end
                if (widx >= IDX_D2_LO && widx <= IDX_D2_HI) begin // R6 R7
                    next_st.wcnt[1] = '0;
                    next_st.acc[5:3] = '0;
                end
                if (widx == IDX_CLKCFG) begin
                    next_st.cfg = {4'h0, s_axi_wdata[3:0]};
                    if (s_axi_wdata[B_SRST]) begin // R4
                        next_st.regs = REGS_INIT;
                        next_st.supply = '0;
                        next_st.cfg = '0;
                        next_st.wcnt = '0;
                        next_st.acc = '0;
                    end
                end
            end
            if (!((widx >= 8'h01 && widx <= 8'h15) || widx == IDX_SUPPLY
                  || widx == IDX_CLKCFG)) begin
                next_st.bresp = RESP_SLVERR;
            end
        end
        // read channel
        ridx = reg_index(s_axi_araddr);
        rd_hs = st.arready & s_axi_arvalid;
        next_st.arready = s_axi_arvalid & ~st.arready & ~st.rvalid;
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (rd_hs) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = RESP_OKAY;
            next_st.rdata = '0;
            for (int i = 1; i <= 21; i++) begin
                if (ridx == 8'(i)) begin
                    next_st.rdata[7:0] = st.regs[i];
                end
            end
            if (ridx == IDX_SUPPLY) begin
                next_st.rdata[7:0] = st.supply;
            end else if (ridx == IDX_CLKCFG) begin
                next_st.rdata[7:0] = st.cfg;
            end else if (ridx == IDX_STATUS) begin
                next_st.rdata[7:0] = {5'h00, ext_mode, run};
            end else if (!(ridx >= 8'h01 && ridx <= 8'h15)) begin
                next_st.rresp = RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register, synchronous reset
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st <= '0;
            st.regs <= REGS_INIT; // R4
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.awready;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rdata = st.rdata;
    assign shared_clock_pin_o = st.cko;
    assign shared_clock_pin_oe = st.cko_oe;
    assign led_current = st.lvl;
    assign boost_feedback = st.fb;
    assign analog_off = st.cfg[B_SLP]; // R17

    ////////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    a_supply_battery: assert property (st.supply[1:0] == 2'h0 |=> boost_feedback[2:0] == 3'h0) // R3
        else $error("battery LED in boost feedback");
    a_supply_blue: assert property (st.supply[1:0] == 2'h1 && st.lvl[2] != 7'h00 // R1
        |=> boost_feedback[2] && !boost_feedback[1])
        else $error("blue routing wrong");
    a_write_rst_one: assert property (wr_hs && s_axi_wstrb[0] && widx >= IDX_D1_LO // R5
        && widx <= IDX_D1_HI |=> st.wcnt[0] == '0)
        else $error("driver one counter not reset");
    a_write_rst_two: assert property (wr_hs && s_axi_wstrb[0] && widx >= IDX_D2_LO // R6
        && widx <= IDX_D2_HI |=> st.wcnt[1] == '0)
        else $error("driver two counter not reset");
    a_freeze_count: assert property (!run[0] && !wr_hs |=> $stable(st.wcnt[0])) // R8
        else $error("stopped counter moved");
    a_sleep_zero: assert property (st.cfg[B_SLP] |=> led_current == '0) // R17
        else $error("current in sleep");
    a_sync_blank: assert property (sync_sel[0] && !st.sy2[0] |=> led_current[20:0] == '0) // R10
        else $error("driver one lit with sync low");
    a_clk_illegal: assert property (st.cfg[B_CKDIR] && !st.cfg[B_CLOCK_RATE_SELECT] && st.cfg[B_SLP] // R16
        |=> !shared_clock_pin_oe)
        else $error("clock driven in prohibited mode");
    a_single_end: assert property (wrap[1] && !run_en[1] && !wr_hs // R9
        |=> !st.regs[IDX_RUN][B_OS2])
        else $error("single cycle not ended");

    c_wrap_cont: cover property (wrap[0] && run_en[0]);
    c_ext_tick: cover property (ext_mode && ext_edge && run[1]);
    c_slope_step: cover property (st.acc[0] != '0 ##1 $changed(st.lvl[0]));
    c_clk_out: cover property (shared_clock_pin_oe && $rose(shared_clock_pin_o));

endmodule : rgbws_top

// >>> bench/rgbws_partner.sv
`timescale 1ns/10ps
// far side: sync sources and a second chip on the shared clock pin
module rgbws_partner (
    input wire logic clk_run,
    input wire logic [1:0] sync_req,
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic [1:0] ext_sync_pin,
    output logic pin_level
);
    logic ref_clk;
    logic drive;
    int extra;
    initial begin
        ref_clk = 1'b0;
        drive = 1'b0;
        extra = 0;
        #3;
    end
    // 31.25 kHz reference, runs on three periods after a stop request
    always begin
        #16000;
        if (clk_run) begin
            drive = 1'b1;
            extra = 3;
            ref_clk = ~ref_clk;
        end else if (extra > 0) begin
            ref_clk = ~ref_clk;
            if (!ref_clk) begin
                extra--;
            end
        end else begin
            drive = 1'b0;
        end
    end
    // sync pins follow the bench request
    assign ext_sync_pin = sync_req;
    // wire level: driver wins, then this chip, else the pull-down
    assign pin_level = pin_oe ? pin_o : (drive ? ref_clk : 1'b0);
endmodule : rgbws_partner

// >>> bench/tb_rgb_wave_sequencer.sv
`timescale 1ns/10ps
module tb_rgb_wave_sequencer;
    import rgbws_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [11:0] s_axi_awaddr = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_awready;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_wready;
    logic [1:0] s_axi_bresp;
    logic s_axi_bvalid;
    logic s_axi_bready = 1'b0;
    logic [11:0] s_axi_araddr = '0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_arready;
    logic [31:0] s_axi_rdata;
    logic [1:0] s_axi_rresp;
    logic s_axi_rvalid;
    logic s_axi_rready = 1'b0;
    logic [1:0] ext_sync_pin;
    logic pin_level;
    logic pin_o;
    logic pin_oe;
    logic [41:0] led_current;
    logic [5:0] boost_feedback;
    logic analog_off;
    logic clk_run = 1'b0;
    logic [1:0] sync_req = 2'b11;
    int failures = 0;
    int n_compared = 0;

    always #4 aclk = ~aclk;

    rgbws_top #(.ADDR_W(12), .CYCLE_TICKS({8{25'h0000040}})) u_dut (
        .aclk(aclk), .aresetn(aresetn),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
        .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .ext_sync_pin(ext_sync_pin),
        .shared_clock_pin_i(pin_level), .shared_clock_pin_o(pin_o),
        .shared_clock_pin_oe(pin_oe), .led_current(led_current),
        .boost_feedback(boost_feedback), .analog_off(analog_off)
    );

    rgbws_partner u_partner (
        .clk_run(clk_run), .sync_req(sync_req), .pin_o(pin_o),
        .pin_oe(pin_oe), .ext_sync_pin(ext_sync_pin), .pin_level(pin_level)
    );

    ////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        if (failures == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    task automatic cmp(input logic [41:0] got, input logic [41:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp

    // write: address and data together, held until ready, then response
    task automatic wr(input logic [7:0] idx, input logic [7:0] val, input logic [3:0] strb,
                      output logic [1:0] resp);
        s_axi_awaddr <= {2'h0, idx, 2'h0};
        s_axi_wdata <= {24'h000000, val};
        s_axi_wstrb <= strb;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        @(posedge aclk);
        // each channel released at its own ready
        while (s_axi_awvalid || s_axi_wvalid) begin
            if (s_axi_awready === 1'b1) begin
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready === 1'b1) begin
                s_axi_wvalid <= 1'b0;
            end
            @(posedge aclk);
        end
        while (s_axi_bvalid !== 1'b1) @(posedge aclk);
        resp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask : wr

    task automatic w(input logic [7:0] idx, input logic [7:0] val);
        logic [1:0] r;
        wr(idx, val, 4'h1, r);
        cmp(r, RESP_OKAY);
    endtask : w

    task automatic rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] resp);
        s_axi_araddr <= {2'h0, idx, 2'h0};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        @(posedge aclk);
        while (s_axi_arready !== 1'b1) @(posedge aclk);
        s_axi_arvalid <= 1'b0;
        @(posedge aclk);
        while (s_axi_rvalid !== 1'b1) @(posedge aclk);
        d = s_axi_rdata;
        resp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask : rd

    // bounded wait for an expected current image
    task automatic wait_eq(input logic [41:0] exp, input int lim);
        for (int i = 0; i < lim && led_current !== exp; i++) @(posedge aclk);
    endtask : wait_eq

    ////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        logic [31:0] d;
        logic [1:0] r;
        cmp(led_current, '0);
        cmp({analog_off, pin_oe}, 2'b00);
        rd(IDX_SUPPLY, d, r);
        cmp(d, 32'h00000000);
        rd(8'h05, d, r);
        cmp(d, {24'h0, PAT_INIT});
        rd(8'hA0, d, r);
        cmp({d, r}, {32'h0, RESP_SLVERR});
        wr(IDX_SUPPLY, 8'h03, 4'h0, r);
        rd(IDX_SUPPLY, d, r);
        cmp({d, r}, {32'h0, RESP_OKAY});
    endtask : t_reset

    // each supply code with driver one lit at level one
    task automatic t_supply();
        logic [2:0] exp [4] = '{3'b000, 3'b100, 3'b110, 3'b111};
        w(8'h03, 8'h08);
        w(8'h06, 8'h08);
        w(8'h09, 8'h08);
        for (int c = 0; c < 4; c++) begin
            w(IDX_SUPPLY, 8'(c));
            w(IDX_RUN, 8'h01);
            wait_eq({21'h0, {3{7'h08}}}, 1000);
            // feedback follows the level one cycle later
            @(posedge aclk);
            cmp(led_current, {21'h0, {3{7'h08}}});
            cmp(boost_feedback, {3'b000, exp[c]});
            w(IDX_RUN, 8'h00);
            wait_eq('0, 1000);
        end
        w(IDX_SUPPLY, 8'h00);
    endtask : t_supply

    task automatic t_sync();
        sync_req <= 2'b10;
        w(IDX_RUN, 8'h05);
        repeat (400) @(posedge aclk);
        cmp(led_current[20:0], '0);
        sync_req <= 2'b11;
        wait_eq({21'h0, {3{7'h08}}}, 1000);
        cmp(led_current[20:0], {3{7'h08}});
        w(IDX_RUN, 8'h00);
        wait_eq('0, 1000);
    endtask : t_sync

    // quarter zero at level two; flags: level one, level two, in between
    task automatic t_blink(input logic [7:0] timing, input logic mid);
        logic s1;
        logic s2;
        logic oth;
        s1 = 1'b0;
        s2 = 1'b0;
        oth = 1'b0;
        w(8'h06, 8'h00);
        w(8'h09, 8'h00);
        w(8'h03, 8'h05);
        w(8'h04, 8'h0A);
        w(8'h05, 8'h06);
        w(IDX_D1_LO, timing);
        w(IDX_RUN, 8'h01);
        repeat (12000) begin
            @(posedge aclk);
            s1 |= (led_current[6:0] === 7'h05);
            s2 |= (led_current[6:0] === 7'h0A);
            oth |= (led_current[6:0] > 7'h05 && led_current[6:0] < 7'h0A);
        end
        cmp({s1, s2, oth}, {2'b11, mid});
        w(IDX_RUN, 8'h00);
        wait_eq('0, 1000);
    endtask : t_blink

    task automatic t_single();
        logic [31:0] d;
        logic [1:0] r;
        w(8'h0D, 8'h10);
        w(8'h0F, 8'h07);
        w(IDX_D2_LO, 8'h00);
        w(IDX_RUN, 8'h20);
        wait_eq({14'h0, 7'h10, 21'h0}, 1000);
        cmp(led_current, {14'h0, 7'h10, 21'h0});
        rd(IDX_STATUS, d, r);
        cmp(d, 32'h00000002);
        wait_eq('0, 10000);
        cmp(led_current, '0);
        rd(IDX_STATUS, d, r);
        cmp(d, 32'h00000000);
    endtask : t_single

    task automatic t_sleep();
        int rises;
        logic lit;
        logic prev;
        rises = 0;
        lit = 1'b0;
        prev = pin_o;
        w(IDX_CLKCFG, 8'h0F);
        cmp({analog_off, pin_oe}, 2'b11);
        w(IDX_RUN, 8'h01);
        repeat (4500) begin
            @(posedge aclk);
            lit |= (led_current !== '0);
            rises += (pin_o === 1'b1 && prev === 1'b0);
            prev = pin_o;
        end
        cmp(lit, 1'b0);
        cmp(rises >= 1, 1'b1);
        w(IDX_RUN, 8'h00);
        w(IDX_CLKCFG, 8'h00);
        cmp({analog_off, pin_oe}, 2'b00);
    endtask : t_sleep

    task automatic t_extclk();
        logic [31:0] d;
        logic [1:0] r;
        w(IDX_CLKCFG, 8'h05);
        clk_run <= 1'b1;
        repeat (100) @(posedge aclk);
        rd(IDX_STATUS, d, r);
        cmp(d, 32'h00000004);
        cmp(pin_oe, 1'b0);
        clk_run <= 1'b0;
        w(IDX_CLKCFG, 8'h00);
    endtask : t_extclk

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_reset();
        t_supply();
        t_sync();
        t_blink(8'h00, 1'b0);
        t_blink(8'h30, 1'b1);
        t_single();
        t_sleep();
        t_extclk();
        complete_run();
    end

    // watchdog well past the expected run length
    initial begin
        #720000;
        failures++;
        complete_run();
    end
endmodule : tb_rgb_wave_sequencer
